// *** rtl/noc_top.sv ***
// numerically controlled oscillator: phase accumulator, output shaping, flags, wishbone registers
// assumes asynchronous clock sources arrive as plain levels and are slower than half of clk
//
// What this block does
// - accumulator carry sets the overflow flag
// - interrupt needs module, local, group, global enables
// - reset clears registers, step low bit0 one
// - oscillator logic runs from selected clock
// - fast oscillator kept on when selected, enabled
// - control bit7 enables the module
// - control bit6 drives output onto pin
// - control bit5 reads present output level
// - control bit4 inverts the output
// - control bit0 selects pulse or toggle mode
// - width field gives two to field periods
// - width applies only in pulse mode
// - clock field selects one of four sources
// - accumulator readable, writable as three bytes
// - unimplemented bits ignore writes, read zero
// - relocate bit picks default or alternate pin
// - each oscillator edge adds step to accumulator, skipped if an accumulator byte is written same cycle
// - toggle mode flips output on each overflow
// - pulse mode output active after overflow
// - low write loads step on second edge, at once while module disabled
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns

module noc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic fast_osc_clk,
  input wire logic logic_cell1_output,
  input wire logic osc_clock_pin,
  output logic fast_osc_keep_on,
  output logic osc_out,
  output logic pin_default_out,
  output logic pin_default_oe_n,
  output logic pin_alt_out,
  output logic pin_alt_oe_n,
  output logic overflow_irq_event
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic noc_hit(input logic [7:0] adr, input logic [7:0] off);
    noc_hit = (adr[7:2] == off[7:2]);
  endfunction

  function automatic logic [7:0] noc_width(input logic [2:0] sel);
    noc_width = 8'h01 << sel;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] control_reg;
  logic [7:0] clock_width_reg;
  logic [19:0] accum_reg;
  logic [7:0] step_low_reg;
  logic [7:0] step_high_reg;
  logic [15:0] step_work_reg;
  logic irq_flag_reg;
  logic [2:0] irq_en_reg;
  logic relocate_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic sel_prev_reg;
  logic raw_reg;
  logic [7:0] pulse_cnt_reg;
  noc_pkg::noc_load_state_type load_reg;
  logic [31:0] wb_dat_r_reg;
  logic wb_ack_reg;
  logic osc_out_reg;
  logic pin_default_out_reg;
  logic pin_default_oe_n_reg;
  logic pin_alt_out_reg;
  logic pin_alt_oe_n_reg;
  logic irq_event_reg;
  logic keep_on_reg;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire bus_req = wb_cyc && wb_stb && !wb_ack_reg;
  wire bus_wr = bus_req && wb_we && wb_sel[0];
  wire [7:0] wdat = wb_dat_w[7:0];
  wire wr_control = bus_wr && noc_hit(wb_adr, noc_pkg::OFF_CONTROL);
  wire wr_clock = bus_wr && noc_hit(wb_adr, noc_pkg::OFF_CLOCK_WIDTH);
  wire wr_acc_l = bus_wr && noc_hit(wb_adr, noc_pkg::OFF_ACCUM_LOW);
  wire wr_acc_h = bus_wr && noc_hit(wb_adr, noc_pkg::OFF_ACCUM_HIGH);
  wire wr_acc_u = bus_wr && noc_hit(wb_adr, noc_pkg::OFF_ACCUM_UPPER);
  wire wr_step_l = bus_wr && noc_hit(wb_adr, noc_pkg::OFF_STEP_LOW);
  wire wr_step_h = bus_wr && noc_hit(wb_adr, noc_pkg::OFF_STEP_HIGH);
  wire wr_irq = bus_wr && noc_hit(wb_adr, noc_pkg::OFF_IRQ_CTRL);
  wire wr_alt = bus_wr && noc_hit(wb_adr, noc_pkg::OFF_ALT_PIN);
  wire wr_acc = wr_acc_l || wr_acc_h || wr_acc_u;

  // decoded fields
  wire module_on = control_reg[noc_pkg::BIT_MODULE_ON];
  wire pulse_mode = control_reg[noc_pkg::BIT_PULSE_MODE];
  wire invert = control_reg[noc_pkg::BIT_INVERT_OUTPUT];
  wire pin_drive = control_reg[noc_pkg::BIT_PIN_DRIVE_ON];
  wire [2:0] width_sel = clock_width_reg[noc_pkg::POS_WIDTH_SEL +: 3];
  wire [1:0] clock_sel = clock_width_reg[noc_pkg::POS_CLOCK_SEL +: 2];

  //////////////////////////////////////////////////////////////////////////////
  // clock source select and edge detect, second sync stage only
  wire sel_level = (clock_sel == noc_pkg::CLK_SRC_FAST_OSC) ? sync2_reg[0] :
                   (clock_sel == noc_pkg::CLK_SRC_LOGIC_CELL) ? sync2_reg[1] : sync2_reg[2];
  wire osc_tick = (clock_sel == noc_pkg::CLK_SRC_SYSTEM) ? 1'b1 : (sel_level && !sel_prev_reg);

  //////////////////////////////////////////////////////////////////////////////
  // accumulator add and software byte writes
  wire [20:0] accum_sum = {1'b0, accum_reg} + {5'h00, step_work_reg};
  wire add_now = osc_tick && module_on && !wr_acc;
  wire carry_evt = add_now && accum_sum[20];
  wire [19:0] accum_next = wr_acc_l ? {accum_reg[19:8], wdat} :
                           wr_acc_h ? {accum_reg[19:16], wdat, accum_reg[7:0]} :
                           wr_acc_u ? {wdat[3:0], accum_reg[15:0]} :
                           add_now ? accum_sum[19:0] : accum_reg;

  //////////////////////////////////////////////////////////////////////////////
  // step buffers and deferred working load
  wire [7:0] step_low_next = wr_step_l ? wdat : step_low_reg;
  wire [7:0] step_high_next = wr_step_h ? wdat : step_high_reg;
  wire load_due = osc_tick && (load_reg == noc_pkg::LOAD_WAIT_LAST);
  wire [15:0] step_work_next = (!module_on || load_due) ? {step_high_next, step_low_next} : step_work_reg;
  noc_pkg::noc_load_state_type load_next;
  always_comb begin
    load_next = load_reg;
    case (load_reg)
      noc_pkg::LOAD_IDLE: begin
        if (wr_step_l && module_on) begin
          load_next = noc_pkg::LOAD_WAIT_FIRST;
        end
      end
      noc_pkg::LOAD_WAIT_FIRST: begin
        if (!module_on) begin
          load_next = noc_pkg::LOAD_IDLE;
        end else if (osc_tick) begin
          load_next = noc_pkg::LOAD_WAIT_LAST;
        end
      end
      noc_pkg::LOAD_WAIT_LAST: begin
        if (!module_on || osc_tick) begin
          load_next = noc_pkg::LOAD_IDLE;
        end
        if (wr_step_l && module_on) begin
          load_next = noc_pkg::LOAD_WAIT_FIRST;
        end
      end
      default: begin
        load_next = noc_pkg::LOAD_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // output shaping: toggle or pulse of selected width
  // a carry during a running pulse restarts the count, so a width longer
  // than the overflow period keeps the output active; software must avoid it
  wire [7:0] pulse_cnt_next = (!module_on || !pulse_mode) ? noc_pkg::RESET_PULSE_CNT :
                              carry_evt ? noc_width(width_sel) :
                              (osc_tick && pulse_cnt_reg != 8'h00) ? pulse_cnt_reg - 8'h01 : pulse_cnt_reg;
  wire raw_next = !module_on ? 1'b0 :
                  pulse_mode ? (pulse_cnt_next != 8'h00) :
                  (raw_reg ^ carry_evt);
  wire level_next = raw_reg ^ invert;

  //////////////////////////////////////////////////////////////////////////////
  // flag and interrupt gating, set wins over the clear
  // the interrupt line is a level that follows the flag while every enable is set
  wire flag_next = carry_evt || (wr_irq ? (irq_flag_reg && wdat[noc_pkg::BIT_IRQ_FLAG]) : irq_flag_reg);
  wire irq_next = irq_flag_reg && module_on && (irq_en_reg == 3'h7);

  //////////////////////////////////////////////////////////////////////////////
  // read mux, unimplemented bits zero
  wire [7:0] rd_control = {control_reg[7:6], osc_out_reg, control_reg[4], 3'h0, control_reg[0]};
  wire [7:0] rd_irq = {4'h0, irq_en_reg, irq_flag_reg};
  wire [7:0] rd_byte = noc_hit(wb_adr, noc_pkg::OFF_CONTROL) ? rd_control :
                       noc_hit(wb_adr, noc_pkg::OFF_CLOCK_WIDTH) ? clock_width_reg :
                       noc_hit(wb_adr, noc_pkg::OFF_ACCUM_LOW) ? accum_reg[7:0] :
                       noc_hit(wb_adr, noc_pkg::OFF_ACCUM_HIGH) ? accum_reg[15:8] :
                       noc_hit(wb_adr, noc_pkg::OFF_ACCUM_UPPER) ? {4'h0, accum_reg[19:16]} :
                       noc_hit(wb_adr, noc_pkg::OFF_STEP_LOW) ? step_low_reg :
                       noc_hit(wb_adr, noc_pkg::OFF_STEP_HIGH) ? step_high_reg :
                       noc_hit(wb_adr, noc_pkg::OFF_IRQ_CTRL) ? rd_irq :
                       noc_hit(wb_adr, noc_pkg::OFF_ALT_PIN) ? {7'h00, relocate_reg} : 8'h00;
  wire [31:0] rd_next = (bus_req && !wb_we) ? {24'h000000, rd_byte} : 32'h00000000;

  // pin routing
  wire drive_default = pin_drive && !relocate_reg;
  wire drive_alt = pin_drive && relocate_reg;

  //////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_reg <= noc_pkg::RESET_BYTE;
      clock_width_reg <= noc_pkg::RESET_BYTE;
      step_low_reg <= noc_pkg::RESET_STEP_LOW;
      step_high_reg <= noc_pkg::RESET_STEP_HIGH;
      irq_en_reg <= 3'h0;
      relocate_reg <= 1'b0;
    end else begin
      if (wr_control) begin
        control_reg <= wdat & noc_pkg::MASK_CONTROL_WR;
      end
      if (wr_clock) begin
        clock_width_reg <= wdat & noc_pkg::MASK_CLOCK_WIDTH;
      end
      step_low_reg <= step_low_next;
      step_high_reg <= step_high_next;
      if (wr_irq) begin
        irq_en_reg <= wdat[noc_pkg::BIT_IRQ_GLOBAL:noc_pkg::BIT_IRQ_ENABLE];
      end
      if (wr_alt) begin
        relocate_reg <= wdat[noc_pkg::BIT_PIN_RELOCATE];
      end
    end
  end

  // oscillator core state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accum_reg <= noc_pkg::RESET_ACCUM;
      step_work_reg <= {noc_pkg::RESET_STEP_HIGH, noc_pkg::RESET_STEP_LOW};
      load_reg <= noc_pkg::LOAD_IDLE;
      raw_reg <= 1'b0;
      pulse_cnt_reg <= noc_pkg::RESET_PULSE_CNT;
      irq_flag_reg <= 1'b0;
    end else begin
      accum_reg <= accum_next;
      step_work_reg <= step_work_next;
      load_reg <= load_next;
      raw_reg <= raw_next;
      pulse_cnt_reg <= pulse_cnt_next;
      irq_flag_reg <= flag_next;
    end
  end

  // synchronisers for asynchronous clock sources
  // only the second stage is read, so a metastable first stage never reaches the edge detector
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sel_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {osc_clock_pin, logic_cell1_output, fast_osc_clk};
      sync2_reg <= sync1_reg;
      sel_prev_reg <= sel_level;
    end
  end

  // registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_dat_r_reg <= 32'h00000000;
      wb_ack_reg <= 1'b0;
      osc_out_reg <= 1'b0;
      pin_default_out_reg <= 1'b0;
      pin_default_oe_n_reg <= 1'b1;
      pin_alt_out_reg <= 1'b0;
      pin_alt_oe_n_reg <= 1'b1;
      irq_event_reg <= 1'b0;
      keep_on_reg <= 1'b0;
    end else begin
      wb_dat_r_reg <= rd_next;
      wb_ack_reg <= bus_req;
      osc_out_reg <= level_next;
      pin_default_out_reg <= level_next;
      pin_default_oe_n_reg <= !drive_default;
      pin_alt_out_reg <= level_next;
      pin_alt_oe_n_reg <= !drive_alt;
      irq_event_reg <= irq_next;
      keep_on_reg <= module_on && (clock_sel == noc_pkg::CLK_SRC_FAST_OSC);
    end
  end

  assign wb_dat_r = wb_dat_r_reg;
  assign wb_ack = wb_ack_reg;
  assign osc_out = osc_out_reg;
  assign pin_default_out = pin_default_out_reg;
  assign pin_default_oe_n = pin_default_oe_n_reg;
  assign pin_alt_out = pin_alt_out_reg;
  assign pin_alt_oe_n = pin_alt_oe_n_reg;
  assign overflow_irq_event = irq_event_reg;
  assign fast_osc_keep_on = keep_on_reg;

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_flag_set_carry: assert property (carry_evt |=> irq_flag_reg)
    else $error("carry did not set overflow flag");
  a_irq_gate_all: assert property (overflow_irq_event |-> $past(irq_flag_reg && module_on && irq_en_reg == 3'h7))
    else $error("interrupt raised without all enables");
  a_flag_held_hw: assert property (irq_flag_reg && !wr_irq |=> irq_flag_reg)
    else $error("flag cleared without software write");
  a_accum_add_step: assert property (add_now |=> accum_reg == $past(accum_sum[19:0]))
    else $error("accumulator did not add step");
  a_disabled_no_add: assert property (!module_on && !wr_acc |=> $stable(accum_reg))
    else $error("accumulator moved while disabled");
  a_toggle_on_carry: assert property (module_on && !pulse_mode && carry_evt |=> raw_reg != $past(raw_reg))
    else $error("toggle mode output did not flip");
  a_pulse_width_load: assert property (module_on && pulse_mode && carry_evt |=> pulse_cnt_reg == noc_width($past(width_sel)) && raw_reg)
    else $error("pulse width count wrong");
  a_pin_drive_map: assert property (!pin_default_oe_n |-> $past(pin_drive && !relocate_reg))
    else $error("default pin driven when not selected");
  a_level_readback: assert property (bus_req && !wb_we && noc_hit(wb_adr, noc_pkg::OFF_CONTROL) |=>
                                     wb_dat_r[5] == $past(osc_out_reg))
    else $error("control read did not return output level");
  a_upper_zero: assert property (wb_ack && noc_hit(wb_adr, noc_pkg::OFF_ACCUM_UPPER) |-> wb_dat_r[7:4] == 4'h0)
    else $error("upper accumulator reserved bits not zero");
  a_step_load_late: assert property (wr_step_l && module_on && load_reg == noc_pkg::LOAD_IDLE |=>
                                     $stable(step_work_reg) ##1 $stable(step_work_reg))
    else $error("working step loaded too early");
  a_polarity_out: assert property (osc_out == $past(raw_reg ^ invert))
    else $error("output polarity wrong");

  // enables and output idle
  a_off_output_idle: assert property (!module_on |=> !raw_reg)
    else $error("output active while module disabled");
  a_irq_off_drop: assert property (!module_on |=> !overflow_irq_event)
    else $error("interrupt raised while module disabled");
  a_keep_on_fast: assert property (module_on && clock_sel == noc_pkg::CLK_SRC_FAST_OSC |=>
                                   fast_osc_keep_on)
    else $error("fast oscillator not held on");

  // pin drive and relocation
  a_pin_released: assert property (!pin_drive |=> pin_default_oe_n && pin_alt_oe_n)
    else $error("pin driven with drive bit clear");
  a_alt_pin_map: assert property (!pin_alt_oe_n |-> $past(pin_drive && relocate_reg))
    else $error("alternate pin driven when not selected");

  // pulse shaping: width ignored in toggle mode, pulse ends after its count
  a_width_ignored: assert property (module_on && !pulse_mode |=> pulse_cnt_reg == 8'h00)
    else $error("pulse count running in toggle mode");
  a_pulse_end: assert property (module_on && pulse_mode && pulse_cnt_reg == 8'h01 && osc_tick && !carry_evt
                                |=> !raw_reg)
    else $error("pulse did not end after its width");

  // register access
  a_ctrl_reserved: assert property (wb_ack && noc_hit(wb_adr, noc_pkg::OFF_CONTROL) |->
                                    wb_dat_r[3:1] == 3'h0)
    else $error("control reserved bits not zero");
  a_accum_byte_wr: assert property (wr_acc_l |=> accum_reg[7:0] == $past(wdat))
    else $error("accumulator low byte write lost");

  // step buffering and flag clear
  a_step_direct_off: assert property (!module_on |=> step_work_reg == {step_high_reg, step_low_reg})
    else $error("working step not loaded while disabled");
  a_flag_sw_clear: assert property (wr_irq && !wdat[noc_pkg::BIT_IRQ_FLAG] && !carry_evt |=>
                                    !irq_flag_reg)
    else $error("software write did not clear flag");

  // main scenarios reached by the bench
  c_carry_seen: cover property (carry_evt);
  c_pulse_done: cover property (pulse_mode && pulse_cnt_reg == 8'h01 && osc_tick);
  c_step_loaded: cover property (load_due && module_on);
  c_irq_out: cover property ($rose(overflow_irq_event));
  c_invert_pulse: cover property (invert && pulse_mode && carry_evt);

endmodule

// *** rtl/noc_pkg.sv ***
// package of the numerically controlled oscillator: register map, field layout, reset values
// assumes a wishbone slave with 32-bit words, 8-bit registers in the low byte
package noc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CLOCK_WIDTH = 8'h04;
  localparam logic [7:0] OFF_ACCUM_LOW = 8'h08;
  localparam logic [7:0] OFF_ACCUM_HIGH = 8'h0C;
  localparam logic [7:0] OFF_ACCUM_UPPER = 8'h10;
  localparam logic [7:0] OFF_STEP_LOW = 8'h14;
  localparam logic [7:0] OFF_STEP_HIGH = 8'h18;
  localparam logic [7:0] OFF_IRQ_CTRL = 8'h1C;
  localparam logic [7:0] OFF_ALT_PIN = 8'h20;

  //////////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int BIT_MODULE_ON = 7;
  localparam int BIT_PIN_DRIVE_ON = 6;
  localparam int BIT_OUTPUT_LEVEL = 5;
  localparam int BIT_INVERT_OUTPUT = 4;
  localparam int BIT_PULSE_MODE = 0;
  localparam logic [7:0] MASK_CONTROL_WR = 8'hD1;

  // clock and width register fields
  localparam int POS_WIDTH_SEL = 5;
  localparam int POS_CLOCK_SEL = 0;
  localparam logic [7:0] MASK_CLOCK_WIDTH = 8'hE3;

  // irq control register fields
  localparam int BIT_IRQ_FLAG = 0;
  localparam int BIT_IRQ_ENABLE = 1;
  localparam int BIT_IRQ_GROUP = 2;
  localparam int BIT_IRQ_GLOBAL = 3;
  localparam logic [7:0] MASK_IRQ_CTRL = 8'h0E;

  // alternate pin register field
  localparam int BIT_PIN_RELOCATE = 0;

  //////////////////////////////////////////////////////////////////////////////
  // sizes and reset values
  localparam int ACCUM_WIDTH = 20;
  localparam int STEP_WIDTH = 16;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_STEP_LOW = 8'h01;
  localparam logic [7:0] RESET_STEP_HIGH = 8'h00;
  localparam logic [19:0] RESET_ACCUM = 20'h00000;
  localparam logic [7:0] RESET_PULSE_CNT = 8'h00;

  // oscillator clock source codes
  localparam logic [1:0] CLK_SRC_FAST_OSC = 2'b00;
  localparam logic [1:0] CLK_SRC_SYSTEM = 2'b01;
  localparam logic [1:0] CLK_SRC_LOGIC_CELL = 2'b10;
  localparam logic [1:0] CLK_SRC_PIN = 2'b11;

  // deferred step load after a low-byte write
  typedef enum logic [1:0] {
    LOAD_IDLE = 2'b00,
    LOAD_WAIT_LAST = 2'b01,
    LOAD_WAIT_FIRST = 2'b10
  } noc_load_state_type;

endpackage

// *** sim/noc_far_side.sv ***
// far-side model: the three oscillator clock sources and the two pads, each with a pull-down
// assumes source half periods are whole multiples of the 40 ns system clock
`timescale 1ns/1ns

module noc_far_side #(
  parameter int FAST_HALF = 240,
  parameter int CELL_HALF = 160,
  parameter int PIN_HALF = 200
) (
  output logic fast_osc_clk,
  output logic logic_cell1_output,
  output logic osc_clock_pin,
  input wire logic pin_default_out,
  input wire logic pin_default_oe_n,
  input wire logic pin_alt_out,
  input wire logic pin_alt_oe_n,
  output logic pad_default,
  output logic pad_alt
);
  //////////////////////////////////////////////////////////////////////////////
  // free-running sources, kept 7 ns off the system clock edges so sampling never races
  initial begin
    fast_osc_clk = 1'b0;
    logic_cell1_output = 1'b0;
    osc_clock_pin = 1'b0;
    #7;
    fork
      forever #(FAST_HALF) fast_osc_clk = ~fast_osc_clk;
      forever #(CELL_HALF) logic_cell1_output = ~logic_cell1_output;
      forever #(PIN_HALF) osc_clock_pin = ~osc_clock_pin;
    join
  end

  // a released pad falls to its pull-down level
  assign pad_default = pin_default_oe_n ? 1'b0 : pin_default_out;
  assign pad_alt = pin_alt_oe_n ? 1'b0 : pin_alt_out;
endmodule

// *** sim/testbench.sv ***
// self-checking bench of the oscillator: register map, clock sources, output shapes, flag
// assumes noc_top answers every bus request one cycle after it is taken
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end

module testbench;
  logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, fast_osc_clk, logic_cell1_output, osc_clock_pin;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic fast_osc_keep_on, osc_out, pin_default_out, pin_default_oe_n, pin_alt_out, pin_alt_oe_n;
  logic overflow_irq_event, pad_default, pad_alt, rnd_bit;
  int mismatches = 0;
  int comparisons = 0;
  int seed = 32'h68D833F5;
  logic [7:0] read_q[$];
  int wave_q[$];
  logic act_lvl = 1'b1;
  logic last_out = 1'b0;
  int seg_len = 0;
  logic [7:0] rnd;
  logic [7:0] offs[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
  logic [7:0] rstv[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  int src_div[4] = '{12, 1, 8, 10};

  noc_top noc_top_i (.clk(clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .fast_osc_clk(fast_osc_clk), .logic_cell1_output(logic_cell1_output), .osc_clock_pin(osc_clock_pin),
    .fast_osc_keep_on(fast_osc_keep_on), .osc_out(osc_out), .pin_default_out(pin_default_out),
    .pin_default_oe_n(pin_default_oe_n), .pin_alt_out(pin_alt_out), .pin_alt_oe_n(pin_alt_oe_n),
    .overflow_irq_event(overflow_irq_event));

  noc_far_side noc_far_side_i (.fast_osc_clk(fast_osc_clk), .logic_cell1_output(logic_cell1_output),
    .osc_clock_pin(osc_clock_pin), .pin_default_out(pin_default_out), .pin_default_oe_n(pin_default_oe_n),
    .pin_alt_out(pin_alt_out), .pin_alt_oe_n(pin_alt_oe_n), .pad_default(pad_default), .pad_alt(pad_alt));

  //////////////////////////////////////////////////////////////////////////////
  // 25 MHz system clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog: the full sequence needs well under 40000 cycles
  initial begin
    #(40 * 40000);
    mismatches++;
    complete_run();
  end

  // watcher: read answers against the oldest note, output segment lengths against theirs
  always @(posedge clk) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && read_q.size() > 0) begin
      `CHK(wb_dat_r, {24'h000000, read_q.pop_front()})
    end
    if (osc_out !== last_out) begin
      if (last_out === act_lvl && wave_q.size() > 0) begin
        `CHK(seg_len, wave_q.pop_front())
      end
      seg_len = 1;
    end else begin
      seg_len++;
    end
    last_out = osc_out;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one classic wishbone cycle, held until the ack edge
  task automatic wb_xfer(input logic we_in, input logic [7:0] adr_in, input logic [7:0] dat_in);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we_in;
    wb_adr <= adr_in;
    wb_sel <= 4'hF;
    wb_dat_w <= {24'h000000, dat_in};
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wb_wr(input logic [7:0] adr_in, input logic [7:0] dat_in);
    wb_xfer(1'b1, adr_in, dat_in);
  endtask

  task automatic wb_rd(input logic [7:0] adr_in, input logic [7:0] exp_in);
    read_q.push_back(exp_in);
    wb_xfer(1'b0, adr_in, 8'h00);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // notes count complete segments at level lvl, then waits for the watcher to use them up
  task automatic expect_segments(input logic lvl, input int len, input int count);
    int n;
    settle(4);
    // skip a segment cut short by a mode or polarity change
    n = 0;
    while (osc_out === lvl && n < len + 8) begin
      @(negedge clk);
      n++;
    end
    act_lvl = lvl;
    repeat (count) wave_q.push_back(len);
    n = 0;
    while (wave_q.size() > 0 && n < 3 * len * count + 500) begin
      @(posedge clk);
      n++;
    end
    if (wave_q.size() > 0) begin
      mismatches++;
      $display("CHECK FAILED at %0t: output segments missing", $time);
      wave_q.delete();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h00000000;
    settle(6);
    `CHK({osc_out, pin_default_oe_n, pin_alt_oe_n}, 3'b011)
    @(posedge clk);
    rst <= 1'b0;
    foreach (offs[i]) wb_rd(offs[i], rstv[i]);
    wb_wr(noc_pkg::OFF_CLOCK_WIDTH, 8'hFF);
    wb_rd(noc_pkg::OFF_CLOCK_WIDTH, 8'hE3);
    wb_wr(noc_pkg::OFF_CLOCK_WIDTH, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd = 8'($random(seed));
      wb_wr(noc_pkg::OFF_ACCUM_LOW, rnd);
      wb_wr(noc_pkg::OFF_ACCUM_UPPER, rnd);
      wb_wr(noc_pkg::OFF_STEP_HIGH, rnd);
      wb_wr(8'h24, rnd);
      wb_rd(noc_pkg::OFF_ACCUM_LOW, rnd);
      wb_rd(noc_pkg::OFF_ACCUM_UPPER, rnd & 8'h0F);
      wb_rd(noc_pkg::OFF_STEP_HIGH, rnd);
    end
    wb_wr(noc_pkg::OFF_CONTROL, 8'h5F);
    wb_rd(noc_pkg::OFF_CONTROL, 8'h71);
    settle(2);
    `CHK({pad_default, pin_alt_oe_n}, 2'b11)
    wb_wr(noc_pkg::OFF_ALT_PIN, 8'h01);
    settle(2);
    `CHK({pin_default_oe_n, pin_alt_oe_n, pad_alt, pad_default}, 4'b1010)
    wb_wr(noc_pkg::OFF_ALT_PIN, 8'h00);
    wb_wr(noc_pkg::OFF_CONTROL, 8'h00);
    wb_rd(noc_pkg::OFF_CONTROL, 8'h00);
    settle(2);
    `CHK({pin_default_oe_n, pad_default}, 2'b10)
    wb_wr(noc_pkg::OFF_STEP_HIGH, 8'h80);
    wb_wr(noc_pkg::OFF_STEP_LOW, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wb_wr(noc_pkg::OFF_CONTROL, 8'h00);
      wb_wr(noc_pkg::OFF_CLOCK_WIDTH, 8'(s));
      wb_wr(noc_pkg::OFF_CONTROL, 8'h80);
      expect_segments(1'b1, 32 * src_div[s], 2);
      `CHK(fast_osc_keep_on, (s == 0))
    end
    wb_wr(noc_pkg::OFF_CLOCK_WIDTH, 8'h01);
    wb_wr(noc_pkg::OFF_IRQ_CTRL, 8'h0F);
    settle(40);
    `CHK(overflow_irq_event, 1'b1)
    wb_wr(noc_pkg::OFF_IRQ_CTRL, 8'h0B);
    settle(2);
    `CHK(overflow_irq_event, 1'b0)
    wb_wr(noc_pkg::OFF_CONTROL, 8'h00);
    wb_rd(noc_pkg::OFF_IRQ_CTRL, 8'h0B);
    wb_wr(noc_pkg::OFF_IRQ_CTRL, 8'h0F);
    settle(2);
    `CHK(overflow_irq_event, 1'b0)
    wb_wr(noc_pkg::OFF_IRQ_CTRL, 8'h0C);
    wb_rd(noc_pkg::OFF_IRQ_CTRL, 8'h0C);
    for (int w = 0; w < 5; w++) begin
      wb_wr(noc_pkg::OFF_CONTROL, 8'h00);
      wb_wr(noc_pkg::OFF_CLOCK_WIDTH, {3'(w), 5'h01});
      wb_wr(noc_pkg::OFF_CONTROL, 8'h81);
      expect_segments(1'b1, 1 << w, 2);
    end
    wb_wr(noc_pkg::OFF_CONTROL, 8'h91);
    expect_segments(1'b0, 16, 2);
    wb_wr(noc_pkg::OFF_CONTROL, 8'h90);
    expect_segments(1'b0, 32, 2);
    wb_wr(noc_pkg::OFF_STEP_HIGH, 8'h40);
    wb_wr(noc_pkg::OFF_STEP_LOW, 8'h00);
    settle(150);
    expect_segments(1'b1, 64, 2);
    wb_rd(noc_pkg::OFF_IRQ_CTRL, 8'h0D);
    complete_run();
  end
endmodule
